/* gpr_port_regs.sv */
// register set and pin drivers for six 8-bit gpio banks a to f
// assumes an avalon-mm master, static legacy strap, pins asynchronous
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module gpr_port_regs #(
  parameter int unsigned BANKS = gpr_pkg::BANKS,
  parameter int unsigned WIDTH = gpr_pkg::WIDTH
) (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic LEGACY_MODE,
  input wire logic [gpr_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [BANKS-1:0][WIDTH-1:0] PIN_IN,
  output logic [BANKS-1:0][WIDTH-1:0] PIN_OUT,
  output logic [BANKS-1:0][WIDTH-1:0] PIN_OE
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  gpr_pkg::gpr_bank_t [BANKS-1:0] bank_r;
  gpr_pkg::gpr_bank_t [BANKS-1:0] bank_nxt;
  logic [BANKS-1:0][WIDTH-1:0] pin_sample;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic req;
  logic [gpr_pkg::ADDR_W-gpr_pkg::BANK_LSB-1:0] bank_idx;
  logic bank_hit;
  gpr_pkg::gpr_sel_t sel;

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  for (genvar b = 0; b < BANKS; b++) begin : g_sync
    gpr_pin_sync #(
      .W(WIDTH)
    ) u_sync (
      .clk(CORE_CLK),
      .pin_async(PIN_IN[b]),
      .pin_sync(pin_sample[b])
    );
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign req = AVS_READ | AVS_WRITE;
  assign bank_idx = AVS_ADDRESS[gpr_pkg::ADDR_W-1:gpr_pkg::BANK_LSB];
  assign bank_hit = (32'(bank_idx) < BANKS);

  always_comb begin
    sel = gpr_pkg::GPR_REG_NONE;
    if (bank_hit && (AVS_ADDRESS[1:0] == 2'h0)) begin
      case (AVS_ADDRESS[gpr_pkg::BANK_LSB-1:0])
        gpr_pkg::OFS_LATCH: sel = gpr_pkg::GPR_REG_LATCH;
        gpr_pkg::OFS_DIR: sel = gpr_pkg::GPR_REG_DIR;
        gpr_pkg::OFS_PIN: sel = gpr_pkg::GPR_REG_PIN;
        default: sel = gpr_pkg::GPR_REG_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bus handshake: one wait cycle, then the access completes
  // ----------------------------------------------------------------
  always_comb begin
    ack_nxt = req & ~ack_r;
  end

  assign AVS_WAITREQUEST = req & ~ack_r;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_comb begin
    bank_nxt = bank_r;
    if (AVS_WRITE && ack_r && AVS_BYTEENABLE[0]) begin
      case (sel)
        gpr_pkg::GPR_REG_LATCH: bank_nxt[bank_idx].latch = AVS_WRITEDATA[WIDTH-1:0];
        gpr_pkg::GPR_REG_DIR: bank_nxt[bank_idx].dir = AVS_WRITEDATA[WIDTH-1:0];
        gpr_pkg::GPR_REG_PIN: bank_nxt = bank_r;
        default: bank_nxt = bank_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read data, registered during the wait cycle
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = rdata_r;
    if (AVS_READ && !ack_r) begin
      rdata_nxt = gpr_pkg::RD_ZERO;
      if (AVS_ADDRESS == gpr_pkg::ADR_STATUS) begin
        rdata_nxt[gpr_pkg::STATUS_LEGACY_BIT] = LEGACY_MODE;
      end else begin
        case (sel)
          gpr_pkg::GPR_REG_LATCH: rdata_nxt[WIDTH-1:0] = bank_r[bank_idx].latch;
          gpr_pkg::GPR_REG_DIR: rdata_nxt[WIDTH-1:0] = bank_r[bank_idx].dir;
          gpr_pkg::GPR_REG_PIN: rdata_nxt[WIDTH-1:0] = pin_sample[bank_idx];
          default: rdata_nxt = gpr_pkg::RD_ZERO;
        endcase
      end
    end
  end

  // asynchronous reset so pins settle with no clock running
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      for (int b = 0; b < BANKS; b++) begin
        bank_r[b].latch <= gpr_pkg::RST_LATCH;
        bank_r[b].dir <= gpr_pkg::RST_DIR;
      end
      ack_r <= 1'b0;
      rdata_r <= gpr_pkg::RD_ZERO;
    end else begin
      bank_r <= bank_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign AVS_READDATA = rdata_r;

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  always_comb begin
    for (int b = 0; b < BANKS; b++) begin
      PIN_OUT[b] = bank_r[b].latch;
      PIN_OE[b] = bank_r[b].dir;
    end
    if (LEGACY_MODE) begin
      // bank c is output-only, latch clears to zero under reset
      PIN_OE[gpr_pkg::BANK_C] = gpr_pkg::ALL_OUT;
      // bank f is input-only in legacy mode
      PIN_OE[gpr_pkg::BANK_F] = gpr_pkg::ALL_IN;
    end
  end

endmodule : gpr_port_regs
`default_nettype wire

/* gpr_pkg.sv */
// package for the six-bank gpio register set
// assumes an avalon-mm slave with 32-bit data and byte addresses
package gpr_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned BANKS = 6;
  localparam int unsigned WIDTH = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned BANK_C = 2;
  localparam int unsigned BANK_F = 5;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_LATCH = 4'h0;
  localparam logic [3:0] OFS_DIR = 4'h4;
  localparam logic [3:0] OFS_PIN = 4'h8;
  localparam logic [ADDR_W-1:0] ADR_STATUS = 7'h60;
  localparam int unsigned BANK_LSB = 4;
  localparam int unsigned STATUS_LEGACY_BIT = 0;

  // ----------------------------------------------------------------
  // reset values and legacy-mode direction masks
  // ----------------------------------------------------------------
  localparam logic [WIDTH-1:0] RST_LATCH = 8'h00;
  localparam logic [WIDTH-1:0] RST_DIR = 8'h00;
  localparam logic [WIDTH-1:0] ALL_OUT = 8'hFF;
  localparam logic [WIDTH-1:0] ALL_IN = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] dir;
  } gpr_bank_t;

  typedef enum logic [1:0] {
    GPR_REG_LATCH,
    GPR_REG_DIR,
    GPR_REG_PIN,
    GPR_REG_NONE
  } gpr_sel_t;

endpackage : gpr_pkg

/* gpr_pin_sync.sv */
// three-stage input synchroniser for one bank of pins
// assumes pins are asynchronous to the clock; no reset, value follows pins
`timescale 1ns/1ps
`default_nettype none
module gpr_pin_sync #(
  parameter int unsigned W = 8
) (
  input wire logic clk,
  input wire logic [W-1:0] pin_async,
  output logic [W-1:0] pin_sync
);

  // ----------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;
  logic [W-1:0] out_nxt;

  // a bit changes once stage two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      out_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : out_r[i];
    end
  end

  // no reset: sampled value depends only on the pins
  always_ff @(posedge clk) begin
    s1_r <= pin_async;
    s2_r <= s1_r;
    s3_r <= s2_r;
    out_r <= out_nxt;
  end

  assign pin_sync = out_r;

endmodule : gpr_pin_sync
`default_nettype wire

/* gpr_port_regs_asserts.sv */
// checker for the gpio register set
// assumes it is bound to gpr_port_regs
`timescale 1ns/1ps
`default_nettype none
module gpr_port_regs_asserts #(
  parameter int unsigned BANKS = 6,
  parameter int unsigned WIDTH = 8
) (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic LEGACY_MODE,
  input wire logic [6:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic [BANKS-1:0][WIDTH-1:0] PIN_IN,
  input wire logic [BANKS-1:0][WIDTH-1:0] PIN_OUT,
  input wire logic [BANKS-1:0][WIDTH-1:0] PIN_OE
);
  // ----
  // properties
  // ----
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  logic acc_w;
  assign acc_w = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] && AVS_ADDRESS[6:4] < 3'h6;
  a_wait_once: assert property ($rose(AVS_READ | AVS_WRITE) |-> AVS_WAITREQUEST ##1
    !AVS_WAITREQUEST) else $error("wait state count wrong");
  a_latch_drive: assert property (acc_w && AVS_ADDRESS[3:0] == 4'h0 |=>
    PIN_OUT[$past(AVS_ADDRESS[6:4])] == $past(AVS_WRITEDATA[7:0])) else $error("latch");
  a_dir_drive: assert property (acc_w && AVS_ADDRESS[3:0] == 4'h4 && !LEGACY_MODE |=>
    PIN_OE[$past(AVS_ADDRESS[6:4])] == $past(AVS_WRITEDATA[7:0])) else $error("dir");
  a_sample_ro: assert property (acc_w && AVS_ADDRESS[3:0] == 4'h8 |=>
    $stable(PIN_OUT) && $stable(PIN_OE)) else $error("sample write took effect");
  a_be_drop: assert property (AVS_WRITE && !AVS_WAITREQUEST && !AVS_BYTEENABLE[0] |=>
    $stable(PIN_OUT) && $stable(PIN_OE)) else $error("masked write took effect");
  a_rd_upper: assert property (AVS_READ && !AVS_WAITREQUEST |->
    AVS_READDATA[31:8] == 24'h000000) else $error("read upper bits");
  a_rd_hold: assert property (!AVS_READ |=> $stable(AVS_READDATA))
    else $error("read data moved");
  a_reset_out: assert property ($rose(NRST) |-> PIN_OUT == '0 && PIN_OE[1:0] == 16'h0000)
    else $error("reset state");
  a_legacy_c: assert property (LEGACY_MODE |-> PIN_OE[2] == 8'hFF)
    else $error("legacy bank c");
endmodule : gpr_port_regs_asserts
bind gpr_port_regs gpr_port_regs_asserts #(.BANKS(BANKS), .WIDTH(WIDTH)) gpr_port_regs_asserts_inst (
  .CORE_CLK(CORE_CLK), .NRST(NRST), .LEGACY_MODE(LEGACY_MODE), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));
`default_nettype wire

/* gpr_pin_model.sv */
// board model for the six pin banks
// assumes the board drives only pins the port leaves undriven
`timescale 1ns/1ps
`default_nettype none
module gpr_pin_model (
  input wire logic [5:0][7:0] pin_out,
  input wire logic [5:0][7:0] pin_oe,
  input wire logic [5:0][7:0] ext,
  output logic [5:0][7:0] pin_in
);
  assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule : gpr_pin_model
`default_nettype wire

/* gpr_port_regs_bench.sv */
// testbench for the gpio register set
// assumes gpr_port_regs, gpr_pin_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t got %h expected %h", $time, (g), (e)); end end
module gpr_port_regs_bench;
  logic core_clk, nrst, legacy_mode, avs_read, avs_write, avs_waitrequest;
  logic [6:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [5:0][7:0] pin_in, pin_out, pin_oe, ext;
  logic [7:0] lat, dir;
  logic [3:0] avs_byteenable;
  int errors, comparisons;
  gpr_port_regs gpr_port_regs_inst (.CORE_CLK(core_clk), .NRST(nrst), .LEGACY_MODE(legacy_mode),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe));
  gpr_pin_model gpr_pin_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
  // ----
  // bus tasks
  // ----
  task end_sim;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : wr
  task rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    `CHK(avs_readdata, {24'h000000, e})
    avs_read <= 1'b0;
  endtask : rd
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    repeat (4000) @(posedge core_clk);
    errors++;
    end_sim();
  end
  // ----
  // tests
  // ----
  initial begin
    errors = 0;
    comparisons = 0;
    nrst = 1'b0;
    legacy_mode = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 7'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    for (int k = 0; k < 6; k++) ext[k] = 8'hC3 ^ 8'(k);
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge core_clk);
    for (int k = 0; k < 6; k++) begin
      lat = 8'hA5 ^ 8'(k);
      dir = 8'h3C;
      rd(7'(k * 16), 8'h00);
      rd(7'(k * 16 + 4), 8'h00);
      rd(7'(k * 16 + 8), ext[k]);
      wr(7'(k * 16), lat);
      wr(7'(k * 16 + 4), dir);
      wr(7'(k * 16 + 8), 8'hFF);
      rd(7'(k * 16), lat);
      rd(7'(k * 16 + 4), dir);
      `CHK(pin_oe[k], dir)
      `CHK(pin_out[k], lat)
      repeat (5) @(posedge core_clk);
      rd(7'(k * 16 + 8), (lat & dir) | (ext[k] & ~dir));
    end
    rd(7'h0C, 8'h00);
    rd(7'h60, 8'h00);
    // write with lane 0 masked must leave the bank a latch alone
    avs_byteenable <= 4'hE;
    wr(7'h00, 8'h5A);
    avs_byteenable <= 4'hF;
    rd(7'h00, 8'hA5);
    rd(7'h01, 8'h00);
    @(posedge core_clk);
    nrst <= 1'b0;
    legacy_mode <= 1'b1;
    #1;
    `CHK(pin_out, 48'h0)
    `CHK(pin_oe, {24'h000000, 8'hFF, 16'h0000})
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    rd(7'h60, 8'h01);
    rd(7'h20, 8'h00);
    // bank c latch reads back zero after the reset in legacy mode
    end_sim();
  end
endmodule : gpr_port_regs_bench
`default_nettype wire
